//--- design/sid_pkg.sv
/*
 * Shared types, field positions and lookup tables for the compact
 * operand decoder.
 * Assumes the fetch stage classifies the halfword into a kind code.
 */
package sid_pkg;

	////////////////////////////////////////////////////////////////////
	// Field positions (low bit of each field) inside the halfword
	localparam int FLD_REG3_A = 7;
	localparam int FLD_REG3_B = 4;
	localparam int FLD_REG3_C = 1;
	localparam int FLD_REG5_A = 5;
	localparam int FLD_REG5_B = 0;
	localparam int FLD_IMM3 = 1;
	localparam int FLD_IMM4 = 0;
	localparam int FLD_IMM5 = 0;
	localparam int FLD_IMM7 = 0;

	////////////////////////////////////////////////////////////////////
	// Implicit register indices and shift decoding
	localparam logic [4:0] GLOBAL_POINTER_REG = 5'h1C;
	localparam logic [4:0] STACK_POINTER_REG = 5'h1D;
	localparam logic [4:0] RETURN_ADDRESS_REG = 5'h1F;
	localparam logic [31:0] SHIFT_CODE_ZERO_COUNT = 32'h0000_0008;
	localparam logic [2:0] SHIFT_CODE_ZERO = 3'h0;

	////////////////////////////////////////////////////////////////////
	// Three-bit specifier tables, entry 0 in the low bits
	localparam logic [7:0][4:0] GEN_MAP =
		{5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h11, 5'h10};
	localparam logic [7:0][4:0] STORE_SRC_MAP =
		{5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h11, 5'h00};
	localparam logic [7:0][4:0] PAIR_SRC_MAP =
		{5'h14, 5'h13, 5'h12, 5'h11, 5'h10, 5'h07, 5'h02, 5'h00};
	localparam logic [7:0][4:0] PAIR_FIRST_MAP =
		{5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h06, 5'h05, 5'h05};
	localparam logic [7:0][4:0] PAIR_SECOND_MAP =
		{5'h07, 5'h06, 5'h05, 5'h16, 5'h15, 5'h07, 5'h07, 5'h06};

	////////////////////////////////////////////////////////////////////
	// Instruction kinds handed over by the fetch stage
	typedef enum logic [4:0] {
		SID_KIND_NONE,
		SID_KIND_ALU3,
		SID_KIND_ALU2,
		SID_KIND_COMPACT_SHIFT_LEFT,
		SID_KIND_COMPACT_SHIFT_RIGHT,
		SID_KIND_COMPACT_STORE_BYTE,
		SID_KIND_COMPACT_STORE_HALF,
		SID_KIND_COMPACT_STORE_WORD,
		SID_KIND_COMPACT_LOAD_WORD,
		SID_KIND_STACK_RELATIVE_LOAD_WORD,
		SID_KIND_STACK_RELATIVE_STORE_WORD,
		SID_KIND_GLOBAL_POINTER_LOAD_WORD,
		SID_KIND_MOVE_MULDIV_RESULT_HIGH,
		SID_KIND_MOVE_MULDIV_RESULT_LOW,
		SID_KIND_COMPACT_REGISTER_MOVE,
		SID_KIND_MOVE_REGISTER_PAIR,
		SID_KIND_JUMP_LINK_REGISTER,
		SID_KIND_PC_RELATIVE
	} sid_kind_type;

	typedef enum logic [1:0] {
		SID_SPECIAL_NONE,
		SID_SPECIAL_MULDIV_RESULT_HIGH,
		SID_SPECIAL_MULDIV_RESULT_LOW,
		SID_SPECIAL_PC
	} sid_special_type;

	typedef struct packed {
		logic valid;
		logic use_a;
		logic [4:0] src_a;
		logic use_b;
		logic [4:0] src_b;
		logic use_dst;
		logic [4:0] dst;
		logic use_dst2;
		logic [4:0] dst2;
		sid_special_type special;
		logic [31:0] imm;
	} sid_operand_type;

	typedef struct packed {
		sid_operand_type op;
	} sid_state_type;

endpackage

//--- design/sid_reg3_map.sv
/*
 * Expands a three-bit register specifier through a lookup table.
 * Assumes the table is given per instance as a parameter.
 */
`timescale 1ns/100ps
`default_nettype none

module sid_reg3_map #(
	parameter logic [7:0][4:0] MAP = '0
) (
	input wire logic [2:0] code_i,
	output logic [4:0] index_o
);

	// Pure table lookup, no state
	assign index_o = MAP[code_i];

endmodule

`default_nettype wire

//--- design/sid_operand_decode.sv
/*
 * Operand decoder for the compact 16-bit instruction format: register
 * indices, implicit operands and decoded immediates, one cycle later.
 * Assumes the fetch stage gives a kind code with each halfword.
 */
// Operation
// - General 3-bit codes 0..7 select registers 16,17,2,3,4,5,6,7.
// - Outputs are 5-bit indices into the one common register file.
// - Compact store data source uses its own map with zero register.
// - Store source codes: 0 to r0, 1 to r17, 2..7 to r2..r7.
// - Five-bit register fields pass through unchanged.
// - Stack, global and return-address registers are supplied implicitly.
// - Multiply/divide high, low and program counter routed without field.
// - Compact shift amount decodes to a count of 1 to 8.
// - Memory offsets are scaled by access size; global offset is signed.
`timescale 1ns/100ps
`default_nettype none

module sid_operand_decode (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic valid_i,
	input wire sid_pkg::sid_kind_type kind_i,
	input wire logic [15:0] insn_i,
	output sid_pkg::sid_operand_type operand_o
);

	sid_pkg::sid_state_type state_q;
	sid_pkg::sid_state_type state_d;
	logic [2:0] f3a;
	logic [2:0] f3b;
	logic [2:0] f3c;
	logic [4:0] f5a;
	logic [4:0] f5b;
	logic [2:0] imm3;
	logic [3:0] imm4;
	logic [4:0] imm5;
	logic [6:0] imm7;
	logic [4:0] gen_a;
	logic [4:0] gen_b;
	logic [4:0] gen_c;
	logic [4:0] store_a;
	logic [4:0] pair_b;
	logic [4:0] pair_c;
	logic [4:0] pair_first;
	logic [4:0] pair_second;

	////////////////////////////////////////////////////////////////////
	// Field extraction
	assign f3a = insn_i[sid_pkg::FLD_REG3_A +: 3];
	assign f3b = insn_i[sid_pkg::FLD_REG3_B +: 3];
	assign f3c = insn_i[sid_pkg::FLD_REG3_C +: 3];
	assign f5a = insn_i[sid_pkg::FLD_REG5_A +: 5];
	assign f5b = insn_i[sid_pkg::FLD_REG5_B +: 5];
	assign imm3 = insn_i[sid_pkg::FLD_IMM3 +: 3];
	assign imm4 = insn_i[sid_pkg::FLD_IMM4 +: 4];
	assign imm5 = insn_i[sid_pkg::FLD_IMM5 +: 5];
	assign imm7 = insn_i[sid_pkg::FLD_IMM7 +: 7];

	////////////////////////////////////////////////////////////////////
	// Specifier expanders, one per field and table
	sid_reg3_map #(.MAP(sid_pkg::GEN_MAP)) u_gen_a (
		.code_i(f3a),
		.index_o(gen_a)
	);
	sid_reg3_map #(.MAP(sid_pkg::GEN_MAP)) u_gen_b (
		.code_i(f3b),
		.index_o(gen_b)
	);
	sid_reg3_map #(.MAP(sid_pkg::GEN_MAP)) u_gen_c (
		.code_i(f3c),
		.index_o(gen_c)
	);
	sid_reg3_map #(.MAP(sid_pkg::STORE_SRC_MAP)) u_store_a (
		.code_i(f3a),
		.index_o(store_a)
	);
	sid_reg3_map #(.MAP(sid_pkg::PAIR_SRC_MAP)) u_pair_b (
		.code_i(f3b),
		.index_o(pair_b)
	);
	sid_reg3_map #(.MAP(sid_pkg::PAIR_SRC_MAP)) u_pair_c (
		.code_i(f3c),
		.index_o(pair_c)
	);
	sid_reg3_map #(.MAP(sid_pkg::PAIR_FIRST_MAP)) u_pair_first (
		.code_i(f3a),
		.index_o(pair_first)
	);
	sid_reg3_map #(.MAP(sid_pkg::PAIR_SECOND_MAP)) u_pair_second (
		.code_i(f3a),
		.index_o(pair_second)
	);

	////////////////////////////////////////////////////////////////////
	// Next operand set; unlisted kind codes yield an invalid bundle
	always_comb begin
		state_d = '0;
		state_d.op.valid = valid_i;
		if (valid_i) begin
			unique case (kind_i)
			sid_pkg::SID_KIND_NONE: begin
			end
			sid_pkg::SID_KIND_ALU3: begin
				state_d.op.use_a = 1'b1;
				state_d.op.src_a = gen_b;
				state_d.op.use_b = 1'b1;
				state_d.op.src_b = gen_c;
				state_d.op.use_dst = 1'b1;
				state_d.op.dst = gen_a;
			end
			sid_pkg::SID_KIND_ALU2: begin
				state_d.op.use_a = 1'b1;
				state_d.op.src_a = gen_b;
				state_d.op.use_dst = 1'b1;
				state_d.op.dst = gen_a;
			end
			sid_pkg::SID_KIND_COMPACT_SHIFT_LEFT,
			sid_pkg::SID_KIND_COMPACT_SHIFT_RIGHT: begin
				state_d.op.use_a = 1'b1;
				state_d.op.src_a = gen_b;
				state_d.op.use_dst = 1'b1;
				state_d.op.dst = gen_a;
				// Code zero means eight, so no shift of zero exists
				if (imm3 == sid_pkg::SHIFT_CODE_ZERO) begin
					state_d.op.imm = sid_pkg::SHIFT_CODE_ZERO_COUNT;
				end else begin
					state_d.op.imm = {29'h0, imm3};
				end
			end
			sid_pkg::SID_KIND_COMPACT_STORE_BYTE,
			sid_pkg::SID_KIND_COMPACT_STORE_HALF,
			sid_pkg::SID_KIND_COMPACT_STORE_WORD: begin
				state_d.op.use_a = 1'b1;
				state_d.op.src_a = gen_b;
				state_d.op.use_b = 1'b1;
				state_d.op.src_b = store_a;
				if (kind_i == sid_pkg::SID_KIND_COMPACT_STORE_BYTE) begin
					state_d.op.imm = {28'h0, imm4};
				end else if (kind_i == sid_pkg::SID_KIND_COMPACT_STORE_HALF) begin
					state_d.op.imm = {27'h0, imm4, 1'b0};
				end else begin
					state_d.op.imm = {26'h0, imm4, 2'h0};
				end
			end
			sid_pkg::SID_KIND_COMPACT_LOAD_WORD: begin
				state_d.op.use_a = 1'b1;
				state_d.op.src_a = gen_b;
				state_d.op.use_dst = 1'b1;
				state_d.op.dst = gen_a;
				state_d.op.imm = {26'h0, imm4, 2'h0};
			end
			sid_pkg::SID_KIND_STACK_RELATIVE_LOAD_WORD: begin
				state_d.op.use_a = 1'b1;
				state_d.op.src_a = sid_pkg::STACK_POINTER_REG;
				state_d.op.use_dst = 1'b1;
				state_d.op.dst = f5a;
				state_d.op.imm = {25'h0, imm5, 2'h0};
			end
			sid_pkg::SID_KIND_STACK_RELATIVE_STORE_WORD: begin
				state_d.op.use_a = 1'b1;
				state_d.op.src_a = sid_pkg::STACK_POINTER_REG;
				state_d.op.use_b = 1'b1;
				state_d.op.src_b = f5a;
				state_d.op.imm = {25'h0, imm5, 2'h0};
			end
			sid_pkg::SID_KIND_GLOBAL_POINTER_LOAD_WORD: begin
				state_d.op.use_a = 1'b1;
				state_d.op.src_a = sid_pkg::GLOBAL_POINTER_REG;
				state_d.op.use_dst = 1'b1;
				state_d.op.dst = gen_a;
				// Signed word offset reaches both sides of the pointer
				state_d.op.imm = {{23{imm7[6]}}, imm7, 2'h0};
			end
			sid_pkg::SID_KIND_MOVE_MULDIV_RESULT_HIGH: begin
				state_d.op.special = sid_pkg::SID_SPECIAL_MULDIV_RESULT_HIGH;
				state_d.op.use_dst = 1'b1;
				state_d.op.dst = f5a;
			end
			sid_pkg::SID_KIND_MOVE_MULDIV_RESULT_LOW: begin
				state_d.op.special = sid_pkg::SID_SPECIAL_MULDIV_RESULT_LOW;
				state_d.op.use_dst = 1'b1;
				state_d.op.dst = f5a;
			end
			sid_pkg::SID_KIND_COMPACT_REGISTER_MOVE: begin
				state_d.op.use_a = 1'b1;
				state_d.op.src_a = f5b;
				state_d.op.use_dst = 1'b1;
				state_d.op.dst = f5a;
			end
			sid_pkg::SID_KIND_MOVE_REGISTER_PAIR: begin
				state_d.op.use_a = 1'b1;
				state_d.op.src_a = pair_b;
				state_d.op.use_b = 1'b1;
				state_d.op.src_b = pair_c;
				state_d.op.use_dst = 1'b1;
				state_d.op.dst = pair_first;
				state_d.op.use_dst2 = 1'b1;
				state_d.op.dst2 = pair_second;
			end
			sid_pkg::SID_KIND_JUMP_LINK_REGISTER: begin
				state_d.op.use_a = 1'b1;
				state_d.op.src_a = f5b;
				state_d.op.use_dst = 1'b1;
				state_d.op.dst = sid_pkg::RETURN_ADDRESS_REG;
			end
			sid_pkg::SID_KIND_PC_RELATIVE: begin
				state_d.op.special = sid_pkg::SID_SPECIAL_PC;
				state_d.op.use_dst = 1'b1;
				state_d.op.dst = gen_a;
			end
			default: begin
				state_d.op.valid = 1'b0;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register; the bundle is registered to cut the path to the
	// register file read ports at the price of one cycle
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign operand_o = state_q.op;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	general_reg_map_a: assert property (
		valid_i && kind_i == sid_pkg::SID_KIND_ALU3 |=>
		operand_o.dst == sid_pkg::GEN_MAP[$past(f3a)] &&
		operand_o.src_b == sid_pkg::GEN_MAP[$past(f3c)])
		else $error("general specifier mapped wrongly");
	store_src_map_a: assert property (
		valid_i && kind_i == sid_pkg::SID_KIND_COMPACT_STORE_WORD &&
		f3a == 3'h0 |=> operand_o.src_b == 5'h00 && operand_o.use_b)
		else $error("store source code zero not register zero");
	store_src_one_a: assert property (
		valid_i && kind_i == sid_pkg::SID_KIND_COMPACT_STORE_BYTE &&
		f3a == 3'h1 |=> operand_o.src_b == 5'h11)
		else $error("store source code one not register 17");
	pass_through_a: assert property (
		valid_i && kind_i == sid_pkg::SID_KIND_COMPACT_REGISTER_MOVE |=>
		operand_o.dst == $past(insn_i[9:5]) &&
		operand_o.src_a == $past(insn_i[4:0]))
		else $error("five-bit field altered");
	implicit_ptr_a: assert property (
		valid_i && kind_i == sid_pkg::SID_KIND_GLOBAL_POINTER_LOAD_WORD |=>
		operand_o.src_a == 5'h1C && operand_o.use_a &&
		!operand_o.use_b)
		else $error("global pointer index wrong");
	link_reg_a: assert property (
		valid_i && kind_i == sid_pkg::SID_KIND_JUMP_LINK_REGISTER |=>
		operand_o.dst == 5'h1F && operand_o.use_dst)
		else $error("return address index wrong");
	special_src_a: assert property (
		valid_i && kind_i == sid_pkg::SID_KIND_MOVE_MULDIV_RESULT_LOW |=>
		operand_o.special == sid_pkg::SID_SPECIAL_MULDIV_RESULT_LOW &&
		!operand_o.use_a)
		else $error("low result source not routed");
	shift_count_a: assert property (
		valid_i && (kind_i == sid_pkg::SID_KIND_COMPACT_SHIFT_LEFT ||
		kind_i == sid_pkg::SID_KIND_COMPACT_SHIFT_RIGHT) |=>
		operand_o.imm >= 32'h1 && operand_o.imm <= 32'h8)
		else $error("shift count outside one to eight");
	glob_offset_a: assert property (
		valid_i && kind_i == sid_pkg::SID_KIND_GLOBAL_POINTER_LOAD_WORD |=>
		$signed(operand_o.imm) == $signed($past(imm7)) * 4)
		else $error("global offset not signed times four");
	half_offset_a: assert property (
		valid_i && kind_i == sid_pkg::SID_KIND_COMPACT_STORE_HALF |=>
		operand_o.imm == {27'h0, $past(imm4), 1'b0})
		else $error("halfword offset not scaled by two");
	pair_dst_a: assert property (
		valid_i && kind_i == sid_pkg::SID_KIND_MOVE_REGISTER_PAIR &&
		f3a == 3'h3 |=> operand_o.dst == 5'h04 && operand_o.dst2 == 5'h15)
		else $error("pair destination code three wrong");

	pair_move_c: cover property (
		valid_i && kind_i == sid_pkg::SID_KIND_MOVE_REGISTER_PAIR);
	shift_eight_c: cover property (
		valid_i && kind_i == sid_pkg::SID_KIND_COMPACT_SHIFT_LEFT &&
		imm3 == 3'h0);
	stack_store_c: cover property (
		valid_i && kind_i == sid_pkg::SID_KIND_STACK_RELATIVE_STORE_WORD);
	back_to_back_c: cover property (valid_i ##1 valid_i);

endmodule

`default_nettype wire

//--- tb/sid_fetch_model.sv
/*
 * Fetch-stage model: hands one compact halfword and its kind per cycle.
 * Assumes the bench calls put() a fixed delay after each rising edge.
 */
`timescale 1ns/100ps
`default_nettype none

module sid_fetch_model (
	output logic valid_o,
	output sid_pkg::sid_kind_type kind_o,
	output logic [15:0] insn_o
);

	////////////////////////////////////////////////////////////////////
	// Idle halfword is inverted so stale data never looks like a match
	task automatic put(input logic v, input sid_pkg::sid_kind_type k,
		input logic [15:0] w);
		valid_o = v;
		kind_o = k;
		insn_o = v ? w : ~insn_o;
	endtask

	// Quiet bus at time zero
	initial begin
		valid_o = 1'b0;
		kind_o = sid_pkg::SID_KIND_NONE;
		insn_o = 16'h0000;
	end

endmodule
`default_nettype wire

//--- tb/test_short_insn_operand_decode.sv
/*
 * Self-checking bench for the compact operand decoder.
 * Assumes one cycle of latency and an all-zero bundle in reset.
 */
`timescale 1ns/100ps
`default_nettype none

module test_short_insn_operand_decode;
	localparam logic Y = 1'b1;
	localparam logic N = 1'b0;
	localparam logic [4:0] Z = 5'h00;
	localparam logic [4:0] GLOB_PTR = 5'h1C;
	localparam logic [4:0] STK_PTR = 5'h1D;
	localparam logic [4:0] LINK_REG = 5'h1F;
	logic [4:0] g[8] = '{5'h10, 5'h11, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07};
	logic [4:0] s[8] = '{5'h00, 5'h11, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07};
	logic [4:0] p1[8] = '{5'h05, 5'h05, 5'h06, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04};
	logic [4:0] p2[8] = '{5'h06, 5'h07, 5'h07, 5'h15, 5'h16, 5'h05, 5'h06, 5'h07};
	logic [4:0] ps[8] = '{5'h00, 5'h02, 5'h07, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};
	logic [15:0] cw[6] = '{16'h0000, 16'hFFFF, 16'h03FF, 16'h0040, 16'h003F, 16'h02A5};
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic valid;
	sid_pkg::sid_kind_type kind;
	logic [15:0] insn;
	sid_pkg::sid_operand_type operand;
	int mismatches = 0;
	int checks_done = 0;

	sid_fetch_model i_fetch (.valid_o(valid), .kind_o(kind), .insn_o(insn));

	sid_operand_decode i_dut (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.valid_i(valid),
		.kind_i(kind),
		.insn_i(insn),
		.operand_o(operand)
	);

	////////////////////////////////////////////////////////////////////
	// 100 MHz clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	function automatic sid_pkg::sid_kind_type kd(input int k);
		return sid_pkg::sid_kind_type'(5'(k));
	endfunction

	// Three-bit fields A, B, C with random spare bits around them
	function automatic logic [15:0] f3(input logic [2:0] a,
		input logic [2:0] b, input logic [2:0] c);
		return {6'($urandom), a, b, c, 1'($urandom)};
	endfunction

	function automatic sid_pkg::sid_operand_type mk(input logic ua,
		input logic [4:0] sa, input logic ub, input logic [4:0] sb,
		input logic ud, input logic [4:0] d, input logic ue,
		input logic [4:0] e, input logic [1:0] spc, input logic [31:0] im);
		return {1'b1, ua, sa, ub, sb, ud, d, ue, e, spc, im};
	endfunction

	// Reference decode; items follow the kind enum order
	function automatic sid_pkg::sid_operand_type exp_op(input logic v,
		input sid_pkg::sid_kind_type k, input logic [15:0] w);
		logic [2:0] a;
		logic [2:0] b;
		logic [2:0] c;
		logic [31:0] i4;
		logic [31:0] i5;
		logic [31:0] sh;
		a = w[9:7];
		b = w[6:4];
		c = w[3:1];
		i4 = {28'h0000000, w[3:0]};
		i5 = {25'h0, w[4:0], 2'h0};
		sh = (c == 3'h0) ? 32'h00000008 : {29'h0, c};
		if (!v) return '0;
		case (5'(k))
		5'h00: return mk(N, Z, N, Z, N, Z, N, Z, 2'h0, 32'h0);
		5'h01: return mk(Y, g[b], Y, g[c], Y, g[a], N, Z, 2'h0, 32'h0);
		5'h02: return mk(Y, g[b], N, Z, Y, g[a], N, Z, 2'h0, 32'h0);
		5'h03, 5'h04: return mk(Y, g[b], N, Z, Y, g[a], N, Z, 2'h0, sh);
		5'h05: return mk(Y, g[b], Y, s[a], N, Z, N, Z, 2'h0, i4);
		5'h06: return mk(Y, g[b], Y, s[a], N, Z, N, Z, 2'h0, i4 << 1);
		5'h07: return mk(Y, g[b], Y, s[a], N, Z, N, Z, 2'h0, i4 << 2);
		5'h08: return mk(Y, g[b], N, Z, Y, g[a], N, Z, 2'h0, i4 << 2);
		5'h09: return mk(Y, STK_PTR, N, Z, Y, w[9:5], N, Z, 2'h0, i5);
		5'h0A: return mk(Y, STK_PTR, Y, w[9:5], N, Z, N, Z, 2'h0, i5);
		5'h0B: return mk(Y, GLOB_PTR, N, Z, Y, g[a], N, Z, 2'h0,
			{{23{w[6]}}, w[6:0], 2'h0});
		5'h0C: return mk(N, Z, N, Z, Y, w[9:5], N, Z, 2'h1, 32'h0);
		5'h0D: return mk(N, Z, N, Z, Y, w[9:5], N, Z, 2'h2, 32'h0);
		5'h0E: return mk(Y, w[4:0], N, Z, Y, w[9:5], N, Z, 2'h0, 32'h0);
		5'h0F: return mk(Y, ps[b], Y, ps[c], Y, p1[a], Y, p2[a], 2'h0, 32'h0);
		5'h10: return mk(Y, w[4:0], N, Z, Y, LINK_REG, N, Z, 2'h0, 32'h0);
		5'h11: return mk(N, Z, N, Z, Y, g[a], N, Z, 2'h3, 32'h0);
		default: return '0;
		endcase
	endfunction

	task automatic chk(input sid_pkg::sid_operand_type e);
		checks_done++;
		if (operand !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h want %h", $time, operand, e);
		end
	endtask

	// One halfword in, its bundle compared one edge later
	task automatic step(input logic v, input sid_pkg::sid_kind_type k,
		input logic [15:0] w);
		sid_pkg::sid_operand_type e;
		e = exp_op(v, k, w);
		i_fetch.put(v, k, w);
		@(posedge clk_i);
		#1;
		chk(e);
	endtask

	task automatic stop_test;
		$display("TB: %0d checks, %0d mismatches", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// Nothing here waits on a handshake; this only catches a stuck run
	initial begin
		#100000;
		mismatches++;
		stop_test();
	end

	initial begin
		void'($urandom(32'h00E8DE06));
		repeat (8) @(posedge clk_i);
		#1;
		chk('0);
		reset_n_i = 1'b1;
		// Every kind with each 3-bit code in every field position
		for (int k = 0; k < 18; k++) begin
			for (int i = 0; i < 8; i++) begin
				step(1'b1, kd(k), f3(3'(i), 3'(i + 3), 3'(i + 5)));
			end
		end
		// Field and offset extremes back to back
		foreach (cw[j]) begin
			for (int k = 3; k < 18; k++) begin
				step(1'b1, kd(k), cw[j]);
			end
		end
		// Refused: idle cycle, then an unknown kind after a global load
		step(1'b0, kd(1), 16'hFFFF);
		step(1'b1, kd(11), 16'h0041);
		step(1'b1, kd(20), 16'h5A5A);
		// Random traffic with an asynchronous reset part way through
		for (int n = 0; n < 400; n++) begin
			if (n == 200) begin
				reset_n_i = 1'b0;
				#1;
				chk('0);
				@(posedge clk_i);
				#1;
				chk('0);
				reset_n_i = 1'b1;
			end
			step($urandom_range(9) != 0, kd($urandom_range(17)), 16'($urandom));
		end
		stop_test();
	end

endmodule
`default_nettype wire
